// File: logic/epf_framer.sv
// Purpose: Builds and parses Ethernet packets in the word-wide buffer RAM.
// Assumes: Buffer RAM ports return read data one cycle after the read strobe.
// Notes: The receive stream carries every byte as seen on the cable.
// Overview of operation
// R01: Status word, byte count word, then data.
// R02: Byte count halved equals total packet words.
// R03: Receive byte count is always even.
// R04: Transmit byte count bit zero is ignored.
// R05: At most six pages, byte count 1536.
// R06: Data starts at offset four, max 1531.
// R07: Transmit addresses exactly as software stored.
// R08: Length/type field passes through as data.
// R09: Control byte sits in last word's high byte.
// R10: Transmit odd flag selects last low byte.
// R11: Control CRC bit matters only when suppressing.
// R12: Receive control byte carries odd flag.
// R13: Receive status written only into memory.
// R14: Flag alignment and checksum faults separately.
// R15: Flag broadcast and multicast frames.
// R16: Flag frames with odd byte count.
// R17: Flag frames above 1518 cable bytes.
// R18: Flag frames below 64 cable bytes.
// R19: Hash is top six destination CRC bits.
// R20: Hash 5:3 picks byte, 2:0 bit.
// R21: Hashed multicast hit always passes filtering.
// R22: Write transmit status; write whole receive packet.
// R23: Status flags at fixed chosen bit positions.
`timescale 1ns/1ps
`include "epf_cfg.svh"

module epf_framer
  import epf_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [AW-1:0] txm_addr,
  output logic txm_rd,
  input wire logic [15:0] txm_rdata,
  output logic txm_wr,
  output logic [15:0] txm_wdata,
  output epf_tx_beat_s tx_beat,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic [15:0] tx_status,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_alignment_fault,
  input wire logic rx_checksum_fault,
  input wire logic rx_addr_match,
  output logic [AW-1:0] rxm_addr,
  output logic rxm_wr,
  output logic [15:0] rxm_wdata,
  output logic rx_filter_pass,
  output logic rx_frame_done
);

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0} ^ (fb ? `EPF_CRC_POLY : 32'h0);
    end
    return r;
  endfunction : crc_byte

  logic [1:0] rst_sync_q;
  logic rst_n;

  // Reset enters asynchronously and is released through two flops.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Register file and bus slave.
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic suppress_checksum_append_q, suppress_checksum_append_d;
  logic [AW-1:0] tx_base_q, tx_base_d, rx_base_q, rx_base_d;
  logic [63:0] mcast_q, mcast_d;
  logic tx_go;
  logic tx_empty_q, tx_empty_d;
  logic tx_busy, rx_busy;
  logic [15:0] rx_frames_q, rx_frames_d;
  logic [7:0] bus_ofs;
  logic bus_wr;

  assign bus_ofs = {3'b000, avs_address, 2'b00};
  assign bus_wr = avs_write && !wait_q;
  assign tx_go = bus_wr && bus_ofs == `EPF_OFS_CTRL && avs_byteenable[0] &&
                 avs_writedata[`EPF_CTRL_GO_BIT];

  always_comb begin
    logic [31:0] cur;
    cur = 32'h0;
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    suppress_checksum_append_d = suppress_checksum_append_q;
    tx_base_d = tx_base_q;
    rx_base_d = rx_base_q;
    mcast_d = mcast_q;
    case (bus_ofs)
      `EPF_OFS_CTRL: cur[`EPF_CTRL_SUPPRESS_BIT] = suppress_checksum_append_q;
      `EPF_OFS_TX_BASE: cur[AW-1:0] = tx_base_q;
      `EPF_OFS_RX_BASE: cur[AW-1:0] = rx_base_q;
      `EPF_OFS_MCAST_LO: cur = mcast_q[31:0];
      `EPF_OFS_MCAST_HI: cur = mcast_q[63:32];
      `EPF_OFS_STATUS: begin
        cur[`EPF_STAT_TX_BUSY_BIT] = tx_busy;
        cur[`EPF_STAT_RX_BUSY_BIT] = rx_busy;
        cur[`EPF_STAT_TX_EMPTY_BIT] = tx_empty_q;
        cur[31:16] = rx_frames_q;
      end
      default: cur = 32'h0;
    endcase
    if (avs_read && wait_q) begin
      rdata_d = cur;
    end
    if (bus_wr) begin
      case (bus_ofs)
        `EPF_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            suppress_checksum_append_d =
              avs_writedata[`EPF_CTRL_SUPPRESS_BIT];
          end
        end
        `EPF_OFS_TX_BASE: tx_base_d = AW'(be_merge(32'(tx_base_q),
                                      avs_writedata, avs_byteenable));
        `EPF_OFS_RX_BASE: rx_base_d = AW'(be_merge(32'(rx_base_q),
                                      avs_writedata, avs_byteenable));
        `EPF_OFS_MCAST_LO: mcast_d[31:0] = be_merge(mcast_q[31:0],
                                           avs_writedata, avs_byteenable);
        `EPF_OFS_MCAST_HI: mcast_d[63:32] = be_merge(mcast_q[63:32],
                                            avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      suppress_checksum_append_q <= 1'b0;
      tx_base_q <= '0;
      rx_base_q <= '0;
      mcast_q <= 64'h0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      suppress_checksum_append_q <= suppress_checksum_append_d;
      tx_base_q <= tx_base_d;
      rx_base_q <= rx_base_d;
      mcast_q <= mcast_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // Transmit reader: count, then control word, then data words in order.
  epf_tx_st_e tx_st_q, tx_st_d;
  logic [AW-1:0] tb_q, tb_d, ta_q, ta_d;
  logic trd_q, trd_d, twr_q, twr_d;
  logic [15:0] twd_q, twd_d, tword_q, tword_d;
  logic [9:0] twords_q, twords_d;
  logic [10:0] trem_q, trem_d;
  logic tsel_q, tsel_d;
  logic tvalid_q, tvalid_d;
  epf_tx_beat_s tbeat_q, tbeat_d;

  assign tx_busy = tx_st_q != TX_IDLE;

  always_comb begin
    logic [10:0] cnt;
    logic [7:0] cb;
    cnt = {txm_rdata[10:1], 1'b0}; // [R04]
    cb = txm_rdata[15:8];
    tx_st_d = tx_st_q;
    tb_d = tb_q;
    ta_d = ta_q;
    trd_d = 1'b0;
    twr_d = 1'b0;
    twd_d = twd_q;
    tword_d = tword_q;
    twords_d = twords_q;
    trem_d = trem_q;
    tsel_d = tsel_q;
    tvalid_d = tvalid_q;
    tbeat_d = tbeat_q;
    tx_empty_d = tx_empty_q;
    case (tx_st_q)
      TX_IDLE: begin
        if (tx_go) begin
          tb_d = tx_base_q;
          ta_d = AW'(tx_base_q + AW'(1)); // [R01]
          trd_d = 1'b1;
          tx_empty_d = 1'b0;
          tx_st_d = TX_CNT0;
        end
      end
      TX_CNT0: tx_st_d = TX_CNT1;
      TX_CNT1: begin
        if (txm_rdata[15:11] != 5'h0 || cnt > `EPF_MAX_BYTE_COUNT) begin
          cnt = `EPF_MAX_BYTE_COUNT; // [R05]
        end
        twords_d = cnt[10:1]; // [R02]
        if (cnt[10:1] <= `EPF_OVERHEAD_WORDS) begin
          tx_empty_d = 1'b1;
          tx_st_d = TX_IDLE;
        end else begin
          ta_d = AW'(tb_q + AW'(cnt[10:1]) - AW'(1)); // [R09]
          trd_d = 1'b1;
          tx_st_d = TX_CW0;
        end
      end
      TX_CW0: tx_st_d = TX_CW1;
      TX_CW1: begin
        trem_d = {(twords_q - `EPF_OVERHEAD_WORDS), 1'b0} +
                 11'(cb[`EPF_CTRLBYTE_ODD_BIT]); // [R10]
        // Without suppression the checksum is always appended.
        tbeat_d.crc_append = !suppress_checksum_append_q ||
                             cb[`EPF_CTRLBYTE_CRC_BIT]; // [R11]
        ta_d = AW'(tb_q + AW'(`EPF_DATA_OFFSET)); // [R06]
        trd_d = 1'b1;
        tx_st_d = TX_FET;
      end
      TX_FET: tx_st_d = TX_LAT;
      TX_LAT: begin
        // Bytes leave untouched, addresses and type field included.
        tword_d = txm_rdata; // [R07] [R08]
        tbeat_d.data = txm_rdata[7:0];
        tbeat_d.last = trem_q == 11'h1;
        tsel_d = 1'b0;
        tvalid_d = 1'b1;
        tx_st_d = TX_SEND;
      end
      TX_SEND: begin
        if (tx_ready) begin
          trem_d = trem_q - 11'h1;
          if (trem_q == 11'h1) begin
            tvalid_d = 1'b0;
            tx_st_d = TX_DONE;
          end else if (tsel_q) begin
            tvalid_d = 1'b0;
            ta_d = AW'(ta_q + AW'(1));
            trd_d = 1'b1;
            tx_st_d = TX_FET;
          end else begin
            tsel_d = 1'b1;
            tbeat_d.data = tword_q[15:8];
            tbeat_d.last = trem_q == 11'h2;
          end
        end
      end
      TX_DONE: begin
        if (tx_done) begin
          ta_d = tb_q;
          twd_d = tx_status;
          twr_d = 1'b1; // [R22]
          tx_st_d = TX_IDLE;
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= TX_IDLE;
      tb_q <= '0;
      ta_q <= '0;
      trd_q <= 1'b0;
      twr_q <= 1'b0;
      twd_q <= 16'h0;
      tword_q <= 16'h0;
      twords_q <= 10'h0;
      trem_q <= 11'h0;
      tsel_q <= 1'b0;
      tvalid_q <= 1'b0;
      tbeat_q <= '0;
      tx_empty_q <= 1'b0;
    end else begin
      tx_st_q <= tx_st_d;
      tb_q <= tb_d;
      ta_q <= ta_d;
      trd_q <= trd_d;
      twr_q <= twr_d;
      twd_q <= twd_d;
      tword_q <= tword_d;
      twords_q <= twords_d;
      trem_q <= trem_d;
      tsel_q <= tsel_d;
      tvalid_q <= tvalid_d;
      tbeat_q <= tbeat_d;
      tx_empty_q <= tx_empty_d;
    end
  end

  assign txm_addr = ta_q;
  assign txm_rd = trd_q;
  assign txm_wr = twr_q;
  assign txm_wdata = twd_q;
  assign tx_valid = tvalid_q;
  assign tx_beat = tbeat_q;

  // Receive writer. The stream has no back-pressure, so the three closing
  // writes need three idle cycles after the last byte of a frame.
  epf_rx_st_e rx_st_q, rx_st_d;
  logic [10:0] rn_q, rn_d;
  logic [7:0] rlo_q, rlo_d;
  logic [31:0] rcrc_q, rcrc_d;
  logic rbc_q, rbc_d, rgrp_q, rgrp_d;
  logic ralign_q, ralign_d, rbad_q, rbad_d;
  logic [AW-1:0] rbase_q, rbase_d, ra_q, ra_d;
  logic rwr_q, rwr_d;
  logic [15:0] rwd_q, rwd_d;
  logic rpass_q, rpass_d, rdone_q, rdone_d;
  epf_rx_stat_s rstat;
  logic [10:0] rstored;

  assign rx_busy = rx_st_q != RX_RUN || rn_q != 11'h0;
  assign rstored = rn_q > `EPF_MAX_DATA_BYTES ? `EPF_MAX_DATA_BYTES : rn_q;

  always_comb begin
    rstat = '0;
    rstat.align_fault = ralign_q; // [R14] [R23]
    rstat.checksum_fault = rbad_q; // [R14]
    rstat.all_stations = rbc_q && rn_q >= `EPF_DA_BYTES; // [R15]
    rstat.group = rgrp_q && !rstat.all_stations; // [R15]
    rstat.uneven = rstored[0]; // [R16]
    rstat.oversize = rn_q > `EPF_CABLE_MAX; // [R17]
    rstat.undersize = rn_q < `EPF_CABLE_MIN; // [R18]
    rstat.hash = rcrc_q[31:26]; // [R19]
  end

  always_comb begin
    logic [31:0] c;
    c = crc_byte(rcrc_q, rx_data);
    rx_st_d = rx_st_q;
    rn_d = rn_q;
    rlo_d = rlo_q;
    rcrc_d = rcrc_q;
    rbc_d = rbc_q;
    rgrp_d = rgrp_q;
    ralign_d = ralign_q;
    rbad_d = rbad_q;
    rbase_d = rbase_q;
    ra_d = ra_q;
    rwr_d = 1'b0;
    rwd_d = rwd_q;
    rpass_d = rpass_q;
    rdone_d = 1'b0;
    rx_frames_d = rx_frames_q;
    case (rx_st_q)
      RX_RUN: begin
        if (rx_valid) begin
          if (rn_q == 11'h0) begin
            rbase_d = rx_base_q;
            rgrp_d = rx_data[0];
          end
          if (rn_q < `EPF_DA_BYTES) begin
            rcrc_d = c;
            rbc_d = rbc_q && rx_data == 8'hff;
          end
          if (rn_q == `EPF_DA_BYTES - 11'h1) begin
            // Hash bits 5:3 pick the table byte and 2:0 the bit in it.
            rpass_d = rx_addr_match || (rgrp_q && mcast_q[c[31:26]]);
          end // [R20] [R21]
          if (rn_q < `EPF_MAX_DATA_BYTES) begin
            if (!rn_q[0]) begin
              rlo_d = rx_data;
            end else begin
              ra_d = AW'((rn_q == 11'h0 ? rx_base_q : rbase_q) +
                         AW'(`EPF_DATA_OFFSET) + AW'(rn_q[10:1]));
              rwd_d = {rx_data, rlo_q}; // [R06] [R08]
              rwr_d = 1'b1;
            end
          end
          if (rn_q != 11'h7ff) begin
            rn_d = rn_q + 11'h1;
          end
          if (rx_last) begin
            ralign_d = rx_alignment_fault;
            rbad_d = rx_checksum_fault;
            rx_st_d = RX_CTRL;
          end
        end
      end
      RX_CTRL: begin
        ra_d = AW'(rbase_q + AW'(`EPF_DATA_OFFSET) + AW'(rstored[10:1]));
        rwd_d = 16'h0;
        rwd_d[8 + `EPF_CTRLBYTE_ODD_BIT] = rstored[0]; // [R09] [R12]
        if (rstored[0]) begin
          rwd_d[7:0] = rlo_q;
        end
        rwr_d = 1'b1;
        rx_st_d = RX_CNT;
      end
      RX_CNT: begin
        ra_d = AW'(rbase_q + AW'(1));
        rwd_d = {5'h0, (`EPF_OVERHEAD_WORDS + rstored[10:1]), 1'b0};
        rwr_d = 1'b1; // [R02] [R03]
        rx_st_d = RX_STAT;
      end
      RX_STAT: begin
        ra_d = rbase_q;
        rwd_d = rstat; // [R13] [R22]
        rwr_d = 1'b1;
        rdone_d = 1'b1;
        rx_frames_d = rx_frames_q + 16'h1;
        rn_d = 11'h0;
        rcrc_d = `EPF_CRC_INIT;
        rbc_d = 1'b1;
        rgrp_d = 1'b0;
        rx_st_d = RX_RUN;
      end
      default: rx_st_d = RX_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= RX_RUN;
      rn_q <= 11'h0;
      rlo_q <= 8'h0;
      rcrc_q <= `EPF_CRC_INIT;
      rbc_q <= 1'b1;
      rgrp_q <= 1'b0;
      ralign_q <= 1'b0;
      rbad_q <= 1'b0;
      rbase_q <= '0;
      ra_q <= '0;
      rwr_q <= 1'b0;
      rwd_q <= 16'h0;
      rpass_q <= 1'b0;
      rdone_q <= 1'b0;
      rx_frames_q <= 16'h0;
    end else begin
      rx_st_q <= rx_st_d;
      rn_q <= rn_d;
      rlo_q <= rlo_d;
      rcrc_q <= rcrc_d;
      rbc_q <= rbc_d;
      rgrp_q <= rgrp_d;
      ralign_q <= ralign_d;
      rbad_q <= rbad_d;
      rbase_q <= rbase_d;
      ra_q <= ra_d;
      rwr_q <= rwr_d;
      rwd_q <= rwd_d;
      rpass_q <= rpass_d;
      rdone_q <= rdone_d;
      rx_frames_q <= rx_frames_d;
    end
  end

  assign rxm_addr = ra_q;
  assign rxm_wr = rwr_q;
  assign rxm_wdata = rwd_q;
  assign rx_filter_pass = rpass_q;
  assign rx_frame_done = rdone_q;

endmodule : epf_framer

// File: logic/epf_cfg.svh
// Purpose: Offsets, field positions, reset values and limits of the framer.
// Assumes: Avalon-MM word addressing with 32-bit data.
// Notes: Register offsets are byte addresses.
`ifndef EPF_CFG_SVH
`define EPF_CFG_SVH

`define EPF_OFS_CTRL 8'h00
`define EPF_OFS_TX_BASE 8'h04
`define EPF_OFS_RX_BASE 8'h08
`define EPF_OFS_MCAST_LO 8'h0c
`define EPF_OFS_MCAST_HI 8'h10
`define EPF_OFS_STATUS 8'h14

`define EPF_CTRL_SUPPRESS_BIT 0
`define EPF_CTRL_GO_BIT 1
`define EPF_STAT_TX_BUSY_BIT 0
`define EPF_STAT_RX_BUSY_BIT 1
`define EPF_STAT_TX_EMPTY_BIT 2

`define EPF_CTRLBYTE_ODD_BIT 5
`define EPF_CTRLBYTE_CRC_BIT 4

`define EPF_PAGE_BYTES 256
`define EPF_MAX_PAGES 6
`define EPF_MAX_BYTE_COUNT 11'h600
`define EPF_DATA_OFFSET 2
`define EPF_MAX_DATA_BYTES 11'h5fb
`define EPF_CABLE_MAX 11'h5ee
`define EPF_CABLE_MIN 11'h040
`define EPF_DA_BYTES 11'h006
`define EPF_OVERHEAD_WORDS 10'h003
`define EPF_CRC_INIT 32'hffffffff
`define EPF_CRC_POLY 32'h04c11db7

`endif

// File: logic/epf_pkg.sv
// Purpose: Types shared by the packet buffer framer.
// Assumes: Constants live in epf_cfg.svh.
// Notes: The status word layout is fixed by epf_rx_stat_s.
package epf_pkg;

  typedef struct packed {
    logic align_fault;
    logic all_stations;
    logic checksum_fault;
    logic uneven;
    logic oversize;
    logic undersize;
    logic [2:0] zero;
    logic [5:0] hash;
    logic group;
  } epf_rx_stat_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic crc_append;
  } epf_tx_beat_s;

  typedef enum logic [3:0] {
    TX_IDLE, TX_CNT0, TX_CNT1, TX_CW0, TX_CW1, TX_FET, TX_LAT, TX_SEND,
    TX_DONE
  } epf_tx_st_e;

  typedef enum logic [1:0] {
    RX_RUN, RX_CTRL, RX_CNT, RX_STAT
  } epf_rx_st_e;

endpackage : epf_pkg

// File: logic/epf_pkg_order_note.sv
`timescale 1ns/1ps

// File: verification/epf_monitor.sv
// Purpose: Port level checks of receive write-back and transmit handshake.
// Assumes: Bound to the framer; AW follows the bound instance.
// Notes: Receive checks key off the status word write or the last receive byte.
`timescale 1ns/1ps
module epf_monitor
  import epf_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire epf_tx_beat_s tx_beat,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic [15:0] tx_status,
  input wire logic txm_wr,
  input wire logic [15:0] txm_wdata,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_alignment_fault,
  input wire logic rx_checksum_fault,
  input wire logic [AW-1:0] rxm_addr,
  input wire logic rxm_wr,
  input wire logic [15:0] rxm_wdata,
  input wire logic rx_frame_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Closing writes: control byte, byte count, then the status word.
  sequence s_close;
    rxm_wr ##1 rxm_wr ##1 (rxm_wr && rx_frame_done);
  endsequence
  sequence s_end;
    rx_valid && rx_last;
  endsequence

  property p_close;
    s_end |-> ##[1:4] s_close;
  endproperty
  a_close: assert property (p_close)
    else $error("receive closing writes missing");
  property p_stat_mem;
    rx_frame_done |-> rxm_wr;
  endproperty
  a_stat_mem: assert property (p_stat_mem)
    else $error("status word not written");
  property p_cnt_addr;
    rx_frame_done |-> $past(rxm_addr) == rxm_addr + AW'(1);
  endproperty
  a_cnt_addr: assert property (p_cnt_addr)
    else $error("count word not after status word");
  property p_words;
    rx_frame_done |-> $past(rxm_addr, 2) ==
      rxm_addr + AW'($past(rxm_wdata) >> 1) - AW'(1);
  endproperty
  a_words: assert property (p_words)
    else $error("control word not at count over two");
  property p_even;
    rx_frame_done |-> !$past(rxm_wdata[0]);
  endproperty
  a_even: assert property (p_even)
    else $error("odd receive byte count");
  property p_max;
    rx_frame_done |-> $past(rxm_wdata) <= 16'h0600;
  endproperty
  a_max: assert property (p_max)
    else $error("receive byte count above limit");
  property p_zero;
    rx_frame_done |-> rxm_wdata[9:7] == 3'h0;
  endproperty
  a_zero: assert property (p_zero)
    else $error("reserved status bits set");
  property p_bcast;
    rx_frame_done |-> !(rxm_wdata[14] && rxm_wdata[0]);
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast frame flagged multicast");
  property p_align;
    s_end and rx_alignment_fault |-> ##[2:4]
      (rx_frame_done && rxm_wdata[15]);
  endproperty
  a_align: assert property (p_align)
    else $error("alignment fault not reported");
  property p_cksum;
    s_end and !rx_checksum_fault |-> ##[2:4]
      (rx_frame_done && !rxm_wdata[13]);
  endproperty
  a_cksum: assert property (p_cksum)
    else $error("checksum fault reported falsely");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat);
  endproperty
  a_hold: assert property (p_hold)
    else $error("transmit byte changed while stalled");
  property p_txstat;
    tx_done |=> txm_wr && txm_wdata == $past(tx_status);
  endproperty
  a_txstat: assert property (p_txstat)
    else $error("transmit status not written back");
endmodule : epf_monitor

bind epf_framer epf_monitor #(.AW(AW)) i_epf_monitor (
  .clk_sys, .arst_n, .tx_beat, .tx_valid, .tx_ready, .tx_done, .tx_status,
  .txm_wr, .txm_wdata, .rx_valid, .rx_last, .rx_alignment_fault,
  .rx_checksum_fault, .rxm_addr, .rxm_wr, .rxm_wdata, .rx_frame_done
);

// File: verification/epf_ram.sv
// Purpose: Buffer RAM and cable sink facing the framer.
// Assumes: One cycle read latency; slow stalls three of four cycles.
// Notes: Idle read data toggles so stale words are never mistaken.
`timescale 1ns/1ps
module epf_ram
  import epf_pkg::*;
#(
  parameter int AW = 12,
  parameter logic [15:0] TX_STAT = 16'h3c5a
) (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [AW-1:0] txm_addr,
  input wire logic txm_rd,
  output logic [15:0] txm_rdata,
  input wire logic txm_wr,
  input wire logic [15:0] txm_wdata,
  input wire logic [AW-1:0] rxm_addr,
  input wire logic rxm_wr,
  input wire logic [15:0] rxm_wdata,
  input wire epf_tx_beat_s tx_beat,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_done,
  output logic [15:0] tx_status
);
  logic [15:0] mem [0:(1<<AW)-1];
  epf_tx_beat_s got [$];
  logic [1:0] cyc = 2'h0;
  initial txm_rdata = 16'h0;
  initial tx_ready = 1'b1;
  initial tx_done = 1'b0;
  assign tx_status = TX_STAT;
  always @(posedge clk_sys) begin
    cyc <= cyc + 2'h1;
    tx_ready <= !slow || cyc == 2'h3;
    txm_rdata <= txm_rd ? mem[txm_addr] : ~txm_rdata;
    if (txm_wr) mem[txm_addr] <= txm_wdata;
    // Word-wide packet store, status, count, data, control.
    if (rxm_wr) mem[rxm_addr] <= rxm_wdata;
    tx_done <= tx_valid && tx_ready && tx_beat.last;
    if (tx_valid && tx_ready) got.push_back(tx_beat);
  end
endmodule : epf_ram

// File: verification/test_epf_framer.sv
// Purpose: Self-checking bench for the packet buffer framer.
// Assumes: Buffers at word 0x100 (transmit) and 0x200 (receive).
// Notes: Expected words are rebuilt from the byte pattern function.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %0t got %h exp %h", $time, g, e); \
end end
module test_epf_framer;
  import epf_pkg::*;
  localparam int TB = 'h100;
  localparam int RB = 'h200;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] txm_addr, rxm_addr;
  logic txm_rd, txm_wr, rxm_wr, tx_valid, tx_ready, tx_done;
  logic [15:0] txm_rdata, txm_wdata, rxm_wdata, tx_status;
  epf_tx_beat_s tx_beat;
  logic slow = 1'b0;
  logic rx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_alignment_fault = 1'b0;
  logic rx_checksum_fault = 1'b0;
  logic rx_addr_match = 1'b0;
  logic rx_filter_pass, rx_frame_done;
  logic [31:0] q;
  int err_total = 0;
  int compares = 0;

  always #4 clk_sys = ~clk_sys;

  epf_framer i_epf_framer (.clk_sys, .arst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .txm_addr, .txm_rd, .txm_rdata, .txm_wr, .txm_wdata,
    .tx_beat, .tx_valid, .tx_ready, .tx_done, .tx_status, .rx_valid,
    .rx_data, .rx_last, .rx_alignment_fault, .rx_checksum_fault,
    .rx_addr_match, .rxm_addr, .rxm_wr, .rxm_wdata, .rx_filter_pass,
    .rx_frame_done);
  epf_ram i_epf_ram (.clk_sys, .slow, .txm_addr, .txm_rd, .txm_rdata,
    .txm_wr, .txm_wdata, .rxm_addr, .rxm_wr, .rxm_wdata, .tx_beat,
    .tx_valid, .tx_ready, .tx_done, .tx_status);

  // Destination taken from the first byte; the rest is a counting pattern.
  function automatic logic [7:0] fb(input logic [7:0] f, input int k);
    if (k < 6) return (k == 0 || f == 8'hff) ? f : 8'h00;
    return 8'(k) + 8'h30;
  endfunction : fb

  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) `CHK(n, 0)
  endtask : bus

  task automatic t_regs();
    bus(1'b1, 3'h1, TB, q);
    bus(1'b1, 3'h2, RB, q);
    bus(1'b1, 3'h3, 32'h0, q);
    bus(1'b1, 3'h4, 32'h80, q);
    bus(1'b0, 3'h1, 32'h0, q);
    `CHK(q, 32'(TB))
    bus(1'b0, 3'h4, 32'h0, q);
    `CHK(q, 32'h80)
    bus(1'b1, 3'h6, 32'hffff, q);
    bus(1'b0, 3'h6, 32'h0, q);
    `CHK(q, 32'h0)
    $display("t_regs done");
  endtask : t_regs

  task automatic t_tx(input int n, input logic sp, cb, ex, sl);
    int k;
    for (k = 0; k < n / 2; k++)
      i_epf_ram.mem[TB+2+k] = {fb(8'h02, 2*k+1), fb(8'h02, 2*k)};
    i_epf_ram.mem[TB+1] = 16'(6 + n / 2 * 2 + 1);
    i_epf_ram.mem[TB+2+n/2] = {2'b00, n[0], cb, 4'h0,
                               n[0] ? fb(8'h02, n-1) : 8'hee};
    i_epf_ram.mem[TB] = 16'h0;
    i_epf_ram.got.delete();
    slow <= sl;
    bus(1'b1, 3'h0, {30'h0, 1'b1, sp}, q);
    k = 0;
    while (i_epf_ram.mem[TB] !== tx_status && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(i_epf_ram.mem[TB], tx_status)
    `CHK(i_epf_ram.got.size(), n)
    for (k = 0; k < n && k < i_epf_ram.got.size(); k++) begin
      `CHK(i_epf_ram.got[k].data, fb(8'h02, k))
      `CHK(i_epf_ram.got[k].last, k == n - 1)
      `CHK(i_epf_ram.got[k].crc_append, ex)
    end
    $display("t_tx done for %0d bytes", n);
  endtask : t_tx

  task automatic rx_frame(input int n, input logic [7:0] f,
                          input logic al, ck);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= fb(f, k);
      rx_last <= (k == n - 1);
      rx_alignment_fault <= al;
      rx_checksum_fault <= ck;
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    k = 0;
    while (rx_frame_done !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 20) `CHK(k, 0)
    repeat (4) @(posedge clk_sys);
  endtask : rx_frame

  task automatic chk_rx(input int n, input logic [7:0] f,
                        input logic [15:0] st, mk);
    int k;
    int s;
    logic [15:0] w;
    s = n > 1531 ? 1531 : n;
    `CHK(i_epf_ram.mem[RB] & mk, st)
    `CHK(i_epf_ram.mem[RB+1], 16'(6 + s / 2 * 2))
    for (k = 0; k < s / 2; k++)
      `CHK(i_epf_ram.mem[RB+2+k], {fb(f, 2*k+1), fb(f, 2*k)})
    w = i_epf_ram.mem[RB+2+s/2];
    `CHK(w[13], s[0])
    if (s[0]) `CHK(w[7:0], fb(f, s - 1))
  endtask : chk_rx

  task automatic t_rx_hash();
    rx_frame(65, 8'h01, 1'b1, 1'b0);
    chk_rx(65, 8'h01, 16'h904f, 16'hffff);
    `CHK(rx_filter_pass, 1'b1)
    $display("t_rx_hash done");
  endtask : t_rx_hash

  task automatic t_rx_bcast();
    rx_frame(20, 8'hff, 1'b0, 1'b1);
    chk_rx(20, 8'hff, 16'h6400, 16'hff81);
    $display("t_rx_bcast done");
  endtask : t_rx_bcast

  task automatic t_rx_sizes();
    int n;
    int sz[4] = '{63, 64, 1518, 1519};
    logic [15:0] e;
    bus(1'b1, 3'h4, 32'h0, q);
    foreach (sz[i]) begin
      n = sz[i];
      e = 16'h004f | {3'h0, n[0], n > 1518, n < 64, 10'h0};
      rx_frame(n, 8'h01, 1'b0, 1'b0);
      chk_rx(n, 8'h01, e, 16'hffff);
      `CHK(rx_filter_pass, 1'b0)
    end
    bus(1'b0, 3'h5, 32'h0, q);
    `CHK(q, 32'h00060000)
    $display("t_rx_sizes done");
  endtask : t_rx_sizes

  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_tx(14, 1'b1, 1'b1, 1'b1, 1'b1);
    t_tx(15, 1'b1, 1'b0, 1'b0, 1'b0);
    t_tx(15, 1'b0, 1'b0, 1'b1, 1'b1);
    t_rx_hash();
    t_rx_bcast();
    t_rx_sizes();
    results();
  end

  // The whole run needs some 3600 cycles; over five times that means a hang.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule : test_epf_framer
